//--- pshp_device.sv
// device end of the parallel slave host port: 16-byte store, flags, host status, irq
// assumes the host pins are asynchronous and firmware drives the user-side strobes
// Operation
// (R1) 8-bit data, one address bit, 16-byte store
// (R2) port works only when enabled
// (R3) enable turns pins input, pull-ups off
// (R4) high-address read returns host status byte
// (R5) high-address write pushes byte into store
// (R6) low-address read pops store byte
// (R7) low-address write pushes store byte
// (R8) write data sampled 0-7 clocks after strobe
// (R9) host checks busy before sending
// (R10) host sends at most 16 bytes
// (R11) first written byte sets busy flag
// (R12) firmware clearing busy clears host copy
// (R13) firmware status value shown to host
// (R14) firmware polls empty before reading
// (R15) cpu transfers byte-wise with software handshake
// (R16) flow controller clears busy once peripheral ready
// (R17) host slower than flow-controller peripheral
// (R18) overrun/underrun flag on too-fast host
// (R19) overrun discards the written byte
// (R20) underrun repeats previous read byte
// (R21) two sources, each with enable
// (R22) irq when enabled flag set, global on
// (R23) empty flag tracks store occupancy
// (R24) disabled port ignores strobes, bus undriven
`timescale 1ns/1ns
module pshp_device #(
    parameter int depth = 16
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    pshp_if.device bus,
    // firmware side
    input wire logic [7:0] port_control_reg,
    input wire logic [6:0] host_status_wr_data,
    input wire logic host_status_wr,
    input wire logic busy_clear,
    input wire logic run_clear,
    input wire logic global_port_irq_enable,
    input wire logic fw_rd,
    input wire logic fw_wr,
    input wire logic [7:0] fw_wr_data,
    output logic [7:0] port_data_reg,
    output logic [7:0] port_status_reg,
    output logic [7:0] host_status_reg,
    output logic pins_input_mode,
    output logic pullups_enable,
    output logic irq
);
    typedef struct packed {
        logic [2:0] cs_s;
        logic [2:0] rd_s;
        logic [2:0] wr_s;
        logic [1:0] a_s;
        logic [7:0] din_s1;
        logic [7:0] din_s2;
        logic [depth-1:0][7:0] mem;
        logic [3:0] wptr;
        logic [3:0] rptr;
        logic [4:0] level;
        logic [2:0] wcnt;
        logic wpend;
        logic busy_flag;
        logic overrun_underrun_flag;
        logic [6:0] host_status;
        logic [7:0] last_rd;
        logic [7:0] dout;
        logic oe_n;
        logic [7:0] fw_data;
        logic irq;
        logic busy_d;
        logic run_d;
    } pshp_dev_state_t;
    pshp_dev_state_t st, next_st;
    logic port_enable, busy_irq_enable, overrun_underrun_irq_enable;
    logic [2:0] write_sample_delay;
    logic cs, rd, wr, a1, rd_fall, wr_fall, rd_rise;
    logic host_push, fw_push, host_pop, fw_pop, any_push, any_pop;
    logic store_empty_flag, store_full;
    logic run_set;
    assign port_enable = port_control_reg[pshp_pkg::ctl_enable_bit];
    assign busy_irq_enable = port_control_reg[pshp_pkg::ctl_busy_ie_bit];
    assign overrun_underrun_irq_enable = port_control_reg[pshp_pkg::ctl_run_ie_bit];
    assign write_sample_delay = port_control_reg[pshp_pkg::ctl_delay_lsb +: 3];
    // stage 1 of each synchroniser is read only by stage 2
    assign cs = !st.cs_s[1];
    assign rd = !st.rd_s[1];
    assign wr = !st.wr_s[1];
    assign a1 = st.a_s[1];
    assign rd_fall = cs && rd && st.rd_s[2];
    assign rd_rise = !rd && !st.rd_s[2];
    assign wr_fall = cs && wr && st.wr_s[2];
    assign store_empty_flag = (st.level == pshp_pkg::level_zero); // [R23]
    assign store_full = (st.level == pshp_pkg::level_full);
    always_comb begin
        host_push = 1'b0;
        host_pop = 1'b0;
        run_set = 1'b0;
        next_st = st;
        next_st.cs_s = {st.cs_s[1:0], bus.host_cs_n};
        next_st.rd_s = {st.rd_s[1:0], bus.host_read_strobe_n};
        next_st.wr_s = {st.wr_s[1:0], bus.host_write_strobe_n};
        next_st.a_s = {st.a_s[0], bus.host_addr_line};
        next_st.din_s1 = bus.bus_data;
        next_st.din_s2 = st.din_s1;
        fw_push = fw_wr && !store_full && port_enable;
        fw_pop = fw_rd && !store_empty_flag && port_enable; // [R14]
        if (port_enable) begin // [R2] [R24]
            // write: count the sampling delay, then take the byte
            if (wr_fall) begin
                next_st.wpend = 1'b1;
                next_st.wcnt = pshp_pkg::delay_zero;
            end else if (st.wpend && st.wcnt != write_sample_delay) begin
                next_st.wcnt = st.wcnt + 3'd1; // [R8]
            end
            if (st.wpend && !wr_fall && st.wcnt == write_sample_delay) begin
                next_st.wpend = 1'b0;
                if (store_full || fw_push) begin
                    next_st.overrun_underrun_flag = 1'b1; // [R18] [R19]
                    run_set = 1'b1;
                end else begin
                    host_push = 1'b1; // [R5] [R7]
                end
            end
            // read: drive bus while strobe is low
            if (rd_fall) begin
                next_st.oe_n = 1'b0;
                if (a1) begin
                    next_st.dout = {st.busy_flag, st.host_status}; // [R4]
                end else if (store_empty_flag || fw_push) begin
                    next_st.dout = st.last_rd; // [R20]
                    next_st.overrun_underrun_flag = 1'b1; // [R18]
                    run_set = 1'b1;
                end else begin
                    host_pop = 1'b1; // [R6]
                    next_st.dout = st.mem[st.rptr];
                    next_st.last_rd = st.mem[st.rptr];
                end
            end else if (rd_rise || !cs) begin
                next_st.oe_n = 1'b1;
            end
        end else begin
            next_st.oe_n = 1'b1;
            next_st.wpend = 1'b0;
        end
        // firmware and host share one port per side: host wins a pop clash, firmware wins a push clash
        fw_pop = fw_pop && !host_pop;
        any_push = host_push || (fw_push && !host_push);
        any_pop = host_pop || fw_pop;
        if (any_push) begin
            next_st.mem[st.wptr] = host_push ? st.din_s2 : fw_wr_data; // [R1]
            next_st.wptr = st.wptr + 4'd1;
        end
        if (fw_pop) begin
            next_st.fw_data = st.mem[st.rptr]; // [R15]
        end
        if (any_pop) begin
            next_st.rptr = st.rptr + 4'd1;
        end
        next_st.level = st.level + {4'd0, any_push} - {4'd0, any_pop};
        if (host_status_wr) begin
            next_st.host_status = host_status_wr_data; // [R13]
        end
        // set wins over the firmware clear
        if (busy_clear) begin
            next_st.busy_flag = 1'b0; // [R12] [R16]
        end
        if (host_push) begin
            next_st.busy_flag = 1'b1; // [R11]
        end
        // a fresh overrun or underrun in the clear cycle must not be lost
        if (run_clear && !run_set) begin
            next_st.overrun_underrun_flag = 1'b0;
        end
        next_st.busy_d = st.busy_flag;
        next_st.run_d = st.overrun_underrun_flag;
        // request raised on each rising enabled flag, dropped once no enabled flag is set
        next_st.irq = global_port_irq_enable &&
            ((busy_irq_enable && st.busy_flag) || (overrun_underrun_irq_enable && st.overrun_underrun_flag)) &&
            (st.irq || (st.busy_flag && !st.busy_d) || (st.overrun_underrun_flag && !st.run_d)); // [R21] [R22]
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.cs_s <= 3'h7;
            st.rd_s <= 3'h7;
            st.wr_s <= 3'h7;
            st.oe_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end
    assign bus.dev_data_out = st.dout;
    assign bus.dev_data_oe_n = st.oe_n || !port_enable; // [R24]
    assign port_data_reg = st.fw_data;
    assign port_status_reg = {store_empty_flag, st.busy_flag, st.overrun_underrun_flag, 5'h00};
    assign host_status_reg = {st.busy_flag, st.host_status}; // [R11]
    assign pins_input_mode = port_enable; // [R3]
    assign pullups_enable = !port_enable; // [R3]
    assign irq = st.irq;
endmodule

//--- pshp_pkg.sv
// package for the parallel slave host port: field positions, reset values, sizes
// assumes nothing beyond a SystemVerilog compiler
package pshp_pkg;
    localparam int data_w = 8;
    localparam int store_depth = 16;
    localparam int ptr_w = 4;
    localparam int delay_w = 3;
    // control byte layout
    localparam int ctl_enable_bit = 7;
    localparam int ctl_busy_ie_bit = 6;
    localparam int ctl_run_ie_bit = 5;
    localparam int ctl_delay_lsb = 2;
    localparam logic [7:0] ctl_reset = 8'h00;
    // status byte layout
    localparam int sta_empty_bit = 7;
    localparam int sta_busy_bit = 6;
    localparam int sta_run_bit = 5;
    localparam logic [7:0] sta_reset = 8'h80;
    localparam logic [6:0] host_status_reset = 7'h00;
    localparam logic [7:0] data_reset = 8'h00;
    localparam logic [3:0] cnt_zero = 4'h0;
    localparam logic [4:0] level_zero = 5'h00;
    localparam logic [4:0] level_full = 5'h10;
    localparam logic [2:0] delay_zero = 3'h0;
    // terminal count of the host end's strobe and gap phases: each phase lasts 9 clocks
    localparam logic [3:0] host_strobe_cycles = 4'h8;
    typedef enum logic [1:0] {
        pshp_xfer_cpu,
        pshp_xfer_flow
    } pshp_mode_t;
endpackage

//--- pshp_if.sv
// interface joining the device end and the host end of the parallel slave port
// resolves the data wire itself from the two output enables, pulled high when neither drives
`timescale 1ns/1ns
interface pshp_if;
    logic host_cs_n;
    logic host_addr_line;
    logic host_read_strobe_n;
    logic host_write_strobe_n;
    logic [7:0] dev_data_out;
    logic dev_data_oe_n;
    logic [7:0] host_data_out;
    logic host_data_oe_n;
    logic [7:0] bus_data;
    // wire level: the device drives if it enables, else the host if it enables, else pulled high
    assign bus_data = !dev_data_oe_n ? dev_data_out : (!host_data_oe_n ? host_data_out : 8'hff);
    modport device (
        input host_cs_n,
        input host_addr_line,
        input host_read_strobe_n,
        input host_write_strobe_n,
        input bus_data,
        output dev_data_out,
        output dev_data_oe_n
    );
    modport host (
        output host_cs_n,
        output host_addr_line,
        output host_read_strobe_n,
        output host_write_strobe_n,
        output host_data_out,
        output host_data_oe_n,
        input bus_data
    );
endinterface

//--- pshp_host.sv
// host end of the parallel slave port: one strobed cycle per request
// assumes user requests arrive on clk_sys; the device end samples pins itself
`timescale 1ns/1ns
module pshp_host (
    input wire logic clk_sys,
    input wire logic rst_n,
    pshp_if.host bus,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_addr,
    input wire logic [7:0] req_data,
    output logic req_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_data
);
    typedef enum logic [1:0] {
        pshp_idle,
        pshp_strobe,
        pshp_gap
    } pshp_hstate_t;
    typedef struct packed {
        pshp_hstate_t state;
        logic [3:0] cnt;
        logic wr;
        logic addr;
        logic [7:0] dout;
        logic [7:0] rdata;
        logic rvalid;
    } pshp_host_state_t;
    pshp_host_state_t st, next_st;
    always_comb begin
        next_st = st;
        next_st.rvalid = 1'b0;
        case (st.state)
            pshp_idle: begin
                if (req_valid) begin
                    next_st.state = pshp_strobe;
                    next_st.wr = req_write;
                    next_st.addr = req_addr;
                    next_st.dout = req_data;
                    next_st.cnt = pshp_pkg::cnt_zero;
                end
            end
            // strobe length keeps the host slower than the device's sampling [R17]
            pshp_strobe: begin
                next_st.cnt = st.cnt + 4'd1;
                if (st.cnt == pshp_pkg::host_strobe_cycles) begin
                    next_st.state = pshp_gap;
                    next_st.cnt = pshp_pkg::cnt_zero;
                    if (!st.wr) begin
                        next_st.rdata = bus.bus_data;
                        next_st.rvalid = 1'b1;
                    end
                end
            end
            pshp_gap: begin
                next_st.cnt = st.cnt + 4'd1;
                if (st.cnt == pshp_pkg::host_strobe_cycles) begin
                    next_st.state = pshp_idle;
                end
            end
            default: begin
                next_st.state = pshp_idle;
            end
        endcase
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    // busy polling and 16-byte batches are the user's protocol [R9] [R10]
    assign req_ready = (st.state == pshp_idle);
    assign rsp_valid = st.rvalid;
    assign rsp_data = st.rdata;
    assign bus.host_cs_n = (st.state != pshp_strobe);
    assign bus.host_addr_line = st.addr;
    assign bus.host_read_strobe_n = !(st.state == pshp_strobe && !st.wr);
    assign bus.host_write_strobe_n = !(st.state == pshp_strobe && st.wr);
    assign bus.host_data_out = st.dout;
    assign bus.host_data_oe_n = !(st.state == pshp_strobe && st.wr);
endmodule

//--- pshp_assertions.sv
// checker for the host-port wire shared by the host end and the device end
// assumes its inputs come straight from the joining interface, one clock domain
`timescale 1ns/1ns
module pshp_assertions (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic host_cs_n,
    input wire logic host_addr_line,
    input wire logic host_read_strobe_n,
    input wire logic host_write_strobe_n,
    input wire logic [7:0] dev_data_out,
    input wire logic dev_data_oe_n,
    input wire logic [7:0] host_data_out,
    input wire logic host_data_oe_n,
    input wire logic [7:0] bus_data
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    a_no_contention: assert property (!(!dev_data_oe_n && !host_data_oe_n))
        else $error("both ends drive the data wire");
    a_strobes_exclusive: assert property (!(!host_read_strobe_n && !host_write_strobe_n))
        else $error("read and write strobes low together");
    a_drive_on_read: assert property ($fell(dev_data_oe_n) |-> !host_read_strobe_n && !host_cs_n)
        else $error("device drives without a selected read");
    a_drive_release: assert property ($rose(host_read_strobe_n) |-> ##[1:5] dev_data_oe_n)
        else $error("device keeps driving after read ends");
    a_no_drive_write: assert property (!host_write_strobe_n |-> dev_data_oe_n)
        else $error("device drives during a host write");
    // sampling delay reaches 7 clocks past sync, so the strobe must last
    a_write_width: assert property ($fell(host_write_strobe_n) |-> (!host_write_strobe_n)[*8])
        else $error("write strobe too short");
    a_host_data_stable: assert property (!host_write_strobe_n && !$past(host_write_strobe_n)
        |-> $stable(host_data_out))
        else $error("host data moves within a write");
    a_dev_data_stable: assert property (!dev_data_oe_n && !$past(dev_data_oe_n)
        |-> $stable(dev_data_out))
        else $error("device data moves within a read");
    a_addr_stable_select: assert property (!host_cs_n && !$past(host_cs_n) |-> $stable(host_addr_line))
        else $error("address moves within a selected cycle");
endmodule

//--- tb_top.sv
// self-checking bench: host end and device end joined by the port interface
// assumes firmware-side strobes are single-cycle pulses taken on the rising edge
`timescale 1ns/1ns
module tb_top;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] ctl = 8'h00;
    logic [6:0] st = 7'h00;
    logic st_wr = 1'b0, busy_clear = 1'b0, run_clear = 1'b0, glob = 1'b0, fw_rd = 1'b0, fw_wr = 1'b0;
    logic [7:0] fw_data = 8'h00, pdat, psta, hsta, rsp_data, q;
    logic pins_in, pull_en, irq, req_ready, rsp_valid;
    logic req_valid = 1'b0, req_write = 1'b0, req_addr = 1'b0;
    logic [7:0] req_data = 8'h00;
    logic [7:0] d [17];
    logic [2:0] dly;
    int bad_count = 0;
    int total_checks = 0;
    pshp_if pif();
    pshp_device #(.depth(pshp_pkg::store_depth)) pshp_device_inst (.clk_sys(clk_sys), .rst_n(rst_n), .bus(pif),
        .port_control_reg(ctl), .host_status_wr_data(st), .host_status_wr(st_wr), .busy_clear(busy_clear),
        .run_clear(run_clear), .global_port_irq_enable(glob), .fw_rd(fw_rd), .fw_wr(fw_wr), .fw_wr_data(fw_data),
        .port_data_reg(pdat), .port_status_reg(psta), .host_status_reg(hsta), .pins_input_mode(pins_in),
        .pullups_enable(pull_en), .irq(irq));
    pshp_host pshp_host_inst (.clk_sys(clk_sys), .rst_n(rst_n), .bus(pif), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_data(req_data), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data));
    pshp_assertions pshp_assertions_inst (.clk_sys(clk_sys), .rst_n(rst_n), .host_cs_n(pif.host_cs_n),
        .host_addr_line(pif.host_addr_line), .host_read_strobe_n(pif.host_read_strobe_n),
        .host_write_strobe_n(pif.host_write_strobe_n), .dev_data_out(pif.dev_data_out),
        .dev_data_oe_n(pif.dev_data_oe_n), .host_data_out(pif.host_data_out),
        .host_data_oe_n(pif.host_data_oe_n), .bus_data(pif.bus_data));
    always #20 clk_sys = ~clk_sys;
    task automatic summarize();
        if (bad_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    function automatic logic [7:0] sta(input logic e, input logic b, input logic r);
        return {e, b, r, 5'h00};
    endfunction
    task automatic settle();
        repeat (2) @(negedge clk_sys);
    endtask
    // one host cycle; read data is caught on the response pulse
    task automatic host_op(input logic wr, input logic a, input logic [7:0] v, output logic [7:0] r);
        int n;
        r = 'x;
        @(negedge clk_sys);
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_data = v;
        @(negedge clk_sys);
        req_valid = 1'b0;
        for (n = 0; n < 60; n++) begin
            @(posedge clk_sys);
            #1;
            if (rsp_valid === 1'b1)
                r = rsp_data;
            if (req_ready === 1'b1)
                break;
        end
        if (n == 60) begin
            bad_count++;
            summarize();
        end
    endtask
    task automatic strobe(input int k);
        @(negedge clk_sys);
        case (k)
            0: st_wr = 1'b1;
            1: busy_clear = 1'b1;
            2: run_clear = 1'b1;
            3: fw_wr = 1'b1;
            default: fw_rd = 1'b1;
        endcase
        @(negedge clk_sys);
        {st_wr, busy_clear, run_clear, fw_wr, fw_rd} = 5'h00;
    endtask
    initial begin
        void'($urandom(32'h4cfa_af90));
        for (int i = 0; i < 17; i++)
            d[i] = 8'($urandom);
        dly = 3'($urandom_range(7, 0));
        repeat (12) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_n = 1'b1;
        check("status", psta, sta(1'b1, 1'b0, 1'b0));
        check("hstatus", hsta, 8'h00);
        check("pins", 8'({pins_in, pull_en}), 8'h01);
        // a disabled port must ignore the host entirely
        host_op(1'b1, 1'b1, d[16], q);
        host_op(1'b0, 1'b1, 8'h00, q);
        check("idle bus", q, 8'hff);
        check("status", psta, sta(1'b1, 1'b0, 1'b0));
        ctl = {3'b110, dly, 2'b00};
        glob = 1'b1;
        st = 7'($urandom);
        strobe(0);
        check("pins", 8'({pins_in, pull_en}), 8'h02);
        host_op(1'b0, 1'b1, 8'h00, q);
        check("hread", q, {1'b0, st});
        host_op(1'b1, 1'b1, d[16], q);
        settle();
        check("status", psta, sta(1'b0, 1'b1, 1'b0));
        check("hstatus", hsta, {1'b1, st});
        check("irq", 8'(irq), 8'h01);
        host_op(1'b0, 1'b1, 8'h00, q);
        check("hread", q, {1'b1, st});
        strobe(4);
        check("pop", pdat, d[16]);
        strobe(1);
        settle();
        host_op(1'b0, 1'b1, 8'h00, q);
        check("hread", q, {1'b0, st});
        check("irq", 8'(irq), 8'h00);
        // seventeen writes, one past the batch limit the last one overruns and is dropped
        // longest sampling delay: the byte is taken just before the strobe ends
        ctl = {3'b101, 3'h7, 2'b00};
        for (int i = 0; i < 17; i++)
            host_op(1'b1, 1'b0, d[i], q);
        settle();
        check("status", psta, sta(1'b0, 1'b1, 1'b1));
        check("irq", 8'(irq), 8'h01);
        for (int i = 0; i < 16; i++) begin
            strobe(4);
            check("pop", pdat, d[i]);
        end
        settle();
        check("status", psta, sta(1'b1, 1'b1, 1'b1));
        strobe(2);
        strobe(1);
        settle();
        check("status", psta, sta(1'b1, 1'b0, 1'b0));
        check("irq", 8'(irq), 8'h00);
        for (int i = 0; i < 2; i++) begin
            fw_data = d[i];
            strobe(3);
        end
        for (int i = 0; i < 3; i++) begin
            host_op(1'b0, 1'b0, 8'h00, q);
            check("dread", q, d[(i < 2) ? i : 1]);
        end
        settle();
        check("status", psta, sta(1'b1, 1'b0, 1'b1));
        summarize();
    end
endmodule
